//--- logic/mem_map_decoder.sv
// memory map, program paging and vector relocation decoder
// assumes: requests are one-cycle strobes synchronous to mclk; arrays and
// external bus sit outside and act on the registered targets
//
// What this block does
// - rom select pin low at reset starts execution at FF80h.
// - on-chip ROM is decoded only in program space.
// - dual-access RAM is four 2K blocks, two accesses per cycle.
// - dual-access RAM at data 0080h-1FFFh, also program when overlay set.
// - single-access RAM is seven 8K blocks, one access each per cycle.
// - data 2000h-7FFFh RAM also appears in program space with overlay.
// - program 18000h-1FFFFh RAM appears in data space with data-map bit.
// - protect bit blocks on-chip access by externally fetched code.
// - with protect, host reads only 1000h-1FFFh; writes always allowed.
// - unmapped program addresses become external accesses.
// - unmapped data addresses go external; on-chip hits have no waits.
// - vectors four words apart; taking one loads the program counter.
// - vectors sit at the 128-word page chosen by the vector pointer.
// - reset sets vector pointer to all ones, reset vector at FF80h.
// - program address is 23 bits, page from the page register.
// - with overlay, offsets 0000-7FFF of every page map to page 0.
// - on-chip ROM appears on program page 0 only.
// - page register at data 001Eh, read/write, cleared by reset.
// - far branch, call, return and data writes to 001Eh load the page register.
// - table read/write use the low 23 accumulator bits.
// - data space is 64K words and not paged.
`timescale 1ns/1ns
module mem_map_decoder
#(
  parameter int PAGE_W = 7
)
(
  // clock, reset, enable
  input  wire logic                mclk,
  input  wire logic                rstn,
  input  wire logic                clk_en,
  // strap and mode bits
  input  wire logic                rom_select_pin,
  input  wire logic                ram_overlay_bit,
  input  wire logic                rom_to_data_map_bit,
  input  wire logic                memory_protect_bit,
  input  wire logic                vptr_load,
  input  wire logic [8:0]          vptr_value,
  // program fetch
  input  wire logic                fetch_req,
  input  wire logic [15:0]         fetch_addr,
  input  wire logic                fetch_from_ext,
  // far branch, call, return
  input  wire logic                far_load,
  input  wire logic [22:0]         far_target,
  // table read and write
  input  wire logic                tbl_req,
  input  wire logic [39:0]         tbl_acc,
  input  wire logic                tbl_from_ext,
  // vectors
  input  wire logic                vec_take,
  input  wire logic [4:0]          vec_num,
  // data access
  input  wire logic                data_req,
  input  wire logic                data_we,
  input  wire logic [15:0]         data_addr,
  input  wire logic [15:0]         data_wdata,
  input  wire logic                data_from_ext,
  // host port
  input  wire logic                hp_req,
  input  wire logic                hp_we,
  input  wire logic [22:0]         hp_addr,
  // decoded program side
  output mem_map_pkg::target_e     fetch_target,
  output logic      [22:0]         fetch_phys,
  output logic      [2:0]          fetch_blk,
  output mem_map_pkg::target_e     tbl_target,
  output logic      [22:0]         tbl_phys,
  output logic      [2:0]          tbl_blk,
  // decoded data side
  output mem_map_pkg::target_e     data_target,
  output logic      [2:0]          data_blk,
  output logic      [15:0]         data_rdata,
  output logic                     data_rvalid,
  output logic                     spram_conflict,
  // host answer
  output logic                     hp_grant,
  output logic                     hp_refused,
  // program counter load and state
  output logic                     pc_load,
  output logic      [15:0]         pc_value,
  output logic      [15:0]         program_page_register,
  output logic      [8:0]          vector_page_pointer,
  output logic                     rom_enabled
);

  if (PAGE_W < 1 || PAGE_W > 7)
  begin : g_bad_page_w
    $error("PAGE_W must lie between 1 and 7");
  end

  logic                 boot_pending;
  logic [22:0]          fetch_full;
  mem_map_pkg::target_e next_fetch_target;
  logic [22:0]          next_fetch_phys;
  logic [2:0]           next_fetch_blk;
  mem_map_pkg::target_e next_tbl_target;
  logic [22:0]          next_tbl_phys;
  logic [2:0]           next_tbl_blk;
  mem_map_pkg::target_e next_data_target;
  logic [2:0]           next_data_blk;
  logic                 page_wr;
  logic                 hp_rd_ok;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // strap, vector pointer, page register
  // ------------------------------------------------------------
  // strap caught in the synchronous reset branch, so it is the level at release
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      rom_enabled <= !rom_select_pin;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      vector_page_pointer <= mem_map_pkg::VPTR_RESET;
    else if (clk_en && vptr_load)
      vector_page_pointer <= vptr_value;
  end

  assign page_wr = data_req && data_we && data_addr == mem_map_pkg::PAGE_REG_ADDR
                   && !(memory_protect_bit && data_from_ext);

  // far load wins over a same-cycle register write
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      program_page_register <= mem_map_pkg::PAGE_RESET;
    else if (clk_en && far_load)
      program_page_register <= 16'(far_target[16 +: PAGE_W]);
    else if (clk_en && page_wr)
      program_page_register <= 16'(data_wdata[PAGE_W-1:0]);
  end

  // ------------------------------------------------------------
  // program side decode
  // ------------------------------------------------------------
  assign fetch_full = {7'(program_page_register[PAGE_W-1:0]), fetch_addr};

  prog_space_decode u_fetch_dec
  (
    .addr     (fetch_full),
    .from_ext (fetch_from_ext),
    .rom_en   (rom_enabled),
    .ovl      (ram_overlay_bit),
    .protect  (memory_protect_bit),
    .target   (next_fetch_target),
    .phys     (next_fetch_phys),
    .blk      (next_fetch_blk)
  );

  prog_space_decode u_tbl_dec
  (
    .addr     (tbl_acc[22:0]),
    .from_ext (tbl_from_ext),
    .rom_en   (rom_enabled),
    .ovl      (ram_overlay_bit),
    .protect  (memory_protect_bit),
    .target   (next_tbl_target),
    .phys     (next_tbl_phys),
    .blk      (next_tbl_blk)
  );

  // mode bits are read live each access, no shadow copy
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      fetch_target <= mem_map_pkg::T_NONE;
      fetch_phys   <= 23'h000000;
      fetch_blk    <= 3'h0;
      tbl_target   <= mem_map_pkg::T_NONE;
      tbl_phys     <= 23'h000000;
      tbl_blk      <= 3'h0;
    end
    else if (clk_en)
    begin
      fetch_target <= fetch_req ? next_fetch_target : mem_map_pkg::T_NONE;
      fetch_phys   <= next_fetch_phys;
      fetch_blk    <= next_fetch_blk;
      tbl_target   <= tbl_req ? next_tbl_target : mem_map_pkg::T_NONE;
      tbl_phys     <= next_tbl_phys;
      tbl_blk      <= next_tbl_blk;
    end
  end

  // ------------------------------------------------------------
  // data side decode
  // ------------------------------------------------------------
  // ROM never answers here; only RAM and registers are on-chip in data space
  always_comb
  begin
    next_data_target = mem_map_pkg::T_EXT;
    next_data_blk    = 3'h0;
    if (data_addr <= mem_map_pkg::MMR_HI)
      next_data_target = mem_map_pkg::T_MMR;
    else if (data_addr <= mem_map_pkg::DPRAM_HI)
    begin
      next_data_target = mem_map_pkg::T_DPRAM;
      next_data_blk    = {1'b0, data_addr[12:11]};
    end
    else if (data_addr <= mem_map_pkg::SPRAM_D_HI)
    begin
      next_data_target = mem_map_pkg::T_SPRAM;
      next_data_blk    = 3'(data_addr[15:13] - mem_map_pkg::SPRAM_D_BLK0);
    end
    else if (rom_to_data_map_bit)
    begin
      next_data_target = mem_map_pkg::T_SPRAM;
      next_data_blk    = 3'(mem_map_pkg::SPRAM_P_BLK0 + {1'b0, data_addr[14:13]});
    end
    if (memory_protect_bit && data_from_ext && next_data_target != mem_map_pkg::T_EXT)
      next_data_target = mem_map_pkg::T_BLOCKED;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      data_target <= mem_map_pkg::T_NONE;
      data_blk    <= 3'h0;
      data_rdata  <= 16'h0000;
      data_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      data_target <= data_req ? next_data_target : mem_map_pkg::T_NONE;
      data_blk    <= next_data_blk;
      data_rvalid <= data_req && !data_we && next_data_target == mem_map_pkg::T_MMR;
      if (data_req && !data_we && data_addr == mem_map_pkg::PAGE_REG_ADDR)
        data_rdata <= program_page_register;
      else
        data_rdata <= 16'h0000;
    end
  end

  // dual-access blocks tolerate a shared cycle, single-access ones do not
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      spram_conflict <= 1'b0;
    else if (clk_en)
      spram_conflict <= data_req && next_data_target == mem_map_pkg::T_SPRAM
        && ((fetch_req && next_fetch_target == mem_map_pkg::T_SPRAM
             && next_fetch_blk == next_data_blk)
         || (tbl_req && next_tbl_target == mem_map_pkg::T_SPRAM
             && next_tbl_blk == next_data_blk));
  end

  // ------------------------------------------------------------
  // host port filter
  // ------------------------------------------------------------
  assign hp_rd_ok = !memory_protect_bit
                    || (hp_addr >= mem_map_pkg::HP_RD_LO && hp_addr <= mem_map_pkg::HP_RD_HI);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      hp_grant   <= 1'b0;
      hp_refused <= 1'b0;
    end
    else if (clk_en)
    begin
      hp_grant   <= hp_req && (hp_we || hp_rd_ok);
      hp_refused <= hp_req && !hp_we && !hp_rd_ok;
    end
  end

  // ------------------------------------------------------------
  // vectors and boot
  // ------------------------------------------------------------
  // boot vector comes first after release; vectors never touch the page
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      boot_pending <= 1'b1;
      pc_load      <= 1'b0;
      pc_value     <= 16'h0000;
    end
    else if (clk_en)
    begin
      pc_load <= boot_pending || vec_take;
      if (boot_pending)
      begin
        boot_pending <= 1'b0;
        pc_value     <= mem_map_pkg::BOOT_VEC;
      end
      else if (vec_take)
        pc_value <= {vector_page_pointer, vec_num, mem_map_pkg::VEC_PAD};
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_boot_vec;
    ($rose(rstn) && clk_en) |=> (pc_load && pc_value == mem_map_pkg::BOOT_VEC);
  endproperty
  a_boot_vec: assert property (p_boot_vec) else $error("boot vector missed");

  property p_vptr_reset;
    !$past(rstn) |-> vector_page_pointer == mem_map_pkg::VPTR_RESET;
  endproperty
  a_vptr_reset: assert property (p_vptr_reset) else $error("pointer not ones");

  property p_vec_addr;
    (clk_en && vec_take && !boot_pending) |=>
      (pc_load && pc_value == {$past(vector_page_pointer), $past(vec_num), 2'b00});
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

  property p_far_page;
    (clk_en && far_load) |=> program_page_register == 16'($past(far_target[22:16]));
  endproperty
  a_far_page: assert property (p_far_page) else $error("far load lost");

  property p_page_hold;
    (!(clk_en && (far_load || page_wr))) |=> $stable(program_page_register);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed");

  property p_no_rom_data;
    data_target != mem_map_pkg::T_ROM;
  endproperty
  a_no_rom_data: assert property (p_no_rom_data) else $error("rom in data space");

  property p_rom_page0;
    fetch_target == mem_map_pkg::T_ROM |-> (fetch_phys[22:16] == 7'h00 && rom_enabled);
  endproperty
  a_rom_page0: assert property (p_rom_page0) else $error("rom off page 0");

  property p_rom_to_data_map_bit_off;
    (clk_en && data_req && data_addr >= 16'h8000 && !rom_to_data_map_bit)
      |=> data_target == mem_map_pkg::T_EXT;
  endproperty
  a_rom_to_data_map_bit_off: assert property (p_rom_to_data_map_bit_off) else $error("upper data not external");

  property p_protect_fetch;
    (clk_en && fetch_req && fetch_from_ext && memory_protect_bit)
      |=> (fetch_target == mem_map_pkg::T_EXT || fetch_target == mem_map_pkg::T_BLOCKED);
  endproperty
  a_protect_fetch: assert property (p_protect_fetch) else $error("protect bypassed");

  property p_hp_read;
    (clk_en && hp_req && !hp_we && memory_protect_bit
     && (hp_addr < 23'h001000 || hp_addr > 23'h001FFF)) |=> (hp_refused && !hp_grant);
  endproperty
  a_hp_read: assert property (p_hp_read) else $error("host read not refused");

  property p_hp_write;
    (clk_en && hp_req && hp_we) |=> hp_grant;
  endproperty
  a_hp_write: assert property (p_hp_write) else $error("host write refused");

  property p_overlay_fold;
    (clk_en && fetch_req && ram_overlay_bit && !fetch_from_ext && fetch_addr >= 16'h2000
     && fetch_addr < 16'h8000) |=> (fetch_target == mem_map_pkg::T_SPRAM
     && fetch_phys[22:16] == 7'h00);
  endproperty
  a_overlay_fold: assert property (p_overlay_fold) else $error("overlay not on page 0");

  c_far:      cover property (clk_en && far_load ##2 fetch_req);
  c_hp_ref:   cover property (hp_refused);
  c_conflict: cover property (spram_conflict);
  c_vector:   cover property (vec_take && !boot_pending ##1 pc_load);

endmodule

//--- logic/mem_map_pkg.sv
// memory map constants and target encoding for the address decoder
// assumes: 16-bit data space, 23-bit paged program space
package mem_map_pkg;

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam logic [15:0] MMR_HI        = 16'h007F;
  localparam logic [15:0] PAGE_REG_ADDR = 16'h001E;
  localparam logic [15:0] DPRAM_LO      = 16'h0080;
  localparam logic [15:0] DPRAM_HI      = 16'h1FFF;
  localparam logic [15:0] SPRAM_D_LO    = 16'h2000;
  localparam logic [15:0] SPRAM_D_HI    = 16'h7FFF;
  localparam logic [15:0] OVL_LIMIT     = 16'h8000;
  localparam logic [15:0] ROM_BASE      = 16'hC000;
  localparam logic [22:0] SPRAM_P_LO    = 23'h018000;
  localparam logic [22:0] SPRAM_P_HI    = 23'h01FFFF;
  localparam logic [22:0] HP_RD_LO      = 23'h001000;
  localparam logic [22:0] HP_RD_HI      = 23'h001FFF;
  localparam logic [2:0]  SPRAM_P_BLK0  = 3'h3;
  localparam logic [2:0]  SPRAM_D_BLK0  = 3'h1;

  // ------------------------------------------------------------
  // reset values and vectors
  // ------------------------------------------------------------
  localparam logic [15:0] PAGE_RESET    = 16'h0000;
  localparam logic [8:0]  VPTR_RESET    = 9'h1FF;
  localparam logic [15:0] BOOT_VEC      = 16'hFF80;
  localparam logic [1:0]  VEC_PAD       = 2'h0;

  typedef enum logic [2:0] {
    T_NONE    = 3'b000,
    T_ROM     = 3'b001,
    T_DPRAM   = 3'b010,
    T_SPRAM   = 3'b011,
    T_EXT     = 3'b100,
    T_BLOCKED = 3'b101,
    T_MMR     = 3'b110
  } target_e;

endpackage

//--- logic/prog_space_decode.sv
// combinational decode of one 23-bit program address
// assumes: mode bits are already valid for the current access
`timescale 1ns/1ns
module prog_space_decode
(
  // address and origin
  input  wire logic [22:0]         addr,
  input  wire logic                from_ext,
  // mode bits
  input  wire logic                rom_en,
  input  wire logic                ovl,
  input  wire logic                protect,
  // result
  output mem_map_pkg::target_e     target,
  output logic      [22:0]         phys,
  output logic      [2:0]          blk
);

  logic [15:0] off;
  logic [6:0]  page;

  assign off  = addr[15:0];
  assign page = addr[22:16];

  always_comb
  begin
    target = mem_map_pkg::T_EXT;
    phys   = addr;
    blk    = 3'h0;
    if (ovl && off < mem_map_pkg::OVL_LIMIT)
    begin
      // common block: every page folds onto page 0
      phys = {7'h00, off};
      if (off >= mem_map_pkg::DPRAM_LO && off <= mem_map_pkg::DPRAM_HI)
      begin
        target = mem_map_pkg::T_DPRAM;
        blk    = {1'b0, off[12:11]};
      end
      else if (off >= mem_map_pkg::SPRAM_D_LO)
      begin
        target = mem_map_pkg::T_SPRAM;
        blk    = 3'(off[15:13] - mem_map_pkg::SPRAM_D_BLK0);
      end
    end
    else if (rom_en && page == 7'h00 && off >= mem_map_pkg::ROM_BASE)
    begin
      target = mem_map_pkg::T_ROM;
    end
    else if (addr >= mem_map_pkg::SPRAM_P_LO && addr <= mem_map_pkg::SPRAM_P_HI)
    begin
      target = mem_map_pkg::T_SPRAM;
      blk    = 3'(mem_map_pkg::SPRAM_P_BLK0 + {1'b0, addr[14:13]});
    end
    // everything else falls through to the external bus
    if (protect && from_ext && target != mem_map_pkg::T_EXT)
      target = mem_map_pkg::T_BLOCKED;
  end

endmodule

//--- testbench/cpu_port_model.sv
// request model for the cpu address generators and the host port
// assumes: each request is held for exactly one mclk cycle, then released
`timescale 1ns/1ns
module cpu_port_model
(
  // clock
  input  wire logic   mclk,
  // program side
  output logic        fetch_req,
  output logic [15:0] fetch_addr,
  output logic        fetch_from_ext,
  output logic        tbl_req,
  output logic [39:0] tbl_acc,
  output logic        tbl_from_ext,
  output logic        far_load,
  output logic [22:0] far_target,
  output logic        vec_take,
  output logic [4:0]  vec_num,
  output logic        vptr_load,
  output logic [8:0]  vptr_value,
  // data side
  output logic        data_req,
  output logic        data_we,
  output logic [15:0] data_addr,
  output logic [15:0] data_wdata,
  output logic        data_from_ext,
  // host port
  output logic        hp_req,
  output logic        hp_we,
  output logic [22:0] hp_addr
);
  initial
  begin
    {fetch_req, fetch_addr, fetch_from_ext, tbl_req, tbl_acc, tbl_from_ext} = '0;
    {far_load, far_target, vec_take, vec_num, vptr_load, vptr_value} = '0;
    {data_req, data_we, data_addr, data_wdata, data_from_ext, hp_req, hp_we, hp_addr} = '0;
  end

  // ------------------------------------------------------------
  // one-cycle requests; released addresses show the inverse, ctl keeps its target value
  // ------------------------------------------------------------
  task automatic fetch(input logic [15:0] a, input logic x);
    @(posedge mclk);
    {fetch_req, fetch_addr, fetch_from_ext} <= {1'b1, a, x};
    @(posedge mclk);
    {fetch_req, fetch_addr} <= {1'b0, ~a};
  endtask

  task automatic tbl(input logic [39:0] a, input logic x);
    @(posedge mclk);
    {tbl_req, tbl_acc, tbl_from_ext} <= {1'b1, a, x};
    @(posedge mclk);
    {tbl_req, tbl_acc} <= {1'b0, ~a};
  endtask

  task automatic data(input logic we, input logic [15:0] a, input logic [15:0] wd,
                      input logic x);
    @(posedge mclk);
    {data_req, data_we, data_addr, data_wdata, data_from_ext} <= {1'b1, we, a, wd, x};
    @(posedge mclk);
    {data_req, data_addr, data_wdata} <= {1'b0, ~a, ~wd};
  endtask

  task automatic host(input logic we, input logic [22:0] a);
    @(posedge mclk);
    {hp_req, hp_we, hp_addr} <= {1'b1, we, a};
    @(posedge mclk);
    {hp_req, hp_addr} <= {1'b0, ~a};
  endtask

  // k: 0 far load, 1 vector, 2 vector pointer load
  task automatic ctl(input logic [1:0] k, input logic [22:0] v);
    @(posedge mclk);
    {far_load, far_target, vec_take, vec_num} <= {k == 2'd0, v, k == 2'd1, v[4:0]};
    {vptr_load, vptr_value} <= {k == 2'd2, v[8:0]};
    @(posedge mclk);
    {far_load, vec_take, vptr_load} <= 3'h0;
  endtask
endmodule

//--- testbench/memory_map_page_decoder_tb.sv
// self-checking bench for the memory map decoder
// assumes: decoded outputs appear one cycle after each request
`timescale 1ns/1ns
module memory_map_page_decoder_tb;
  localparam int LIMIT = 5000;
  logic        mclk, rstn, clk_en, rom_select_pin, ovl, map, prot;
  logic        fetch_req, fetch_from_ext, tbl_req, tbl_from_ext, far_load, vec_take;
  logic        vptr_load, data_req, data_we, data_from_ext, hp_req, hp_we;
  logic [15:0] fetch_addr, data_addr, data_wdata, data_rdata, pc_value;
  logic [15:0] program_page_register, page;
  logic [39:0] tbl_acc;
  logic [22:0] far_target, hp_addr, fetch_phys, tbl_phys, tgt;
  logic [22:0] hl [4];
  logic [8:0]  vptr_value, vector_page_pointer, ptr;
  logic [4:0]  vec_num, n;
  logic [2:0]  fetch_blk, tbl_blk, data_blk;
  logic        data_rvalid, spram_conflict, hp_grant, hp_refused, pc_load, rom_enabled;
  logic [31:0] r;
  int          cycles, miscompares, cmp_count;
  mem_map_pkg::target_e fetch_target, tbl_target, data_target;

  cpu_port_model cpu
  (
    .mclk, .fetch_req, .fetch_addr, .fetch_from_ext, .tbl_req, .tbl_acc, .tbl_from_ext,
    .far_load, .far_target, .vec_take, .vec_num, .vptr_load, .vptr_value, .data_req,
    .data_we, .data_addr, .data_wdata, .data_from_ext, .hp_req, .hp_we, .hp_addr
  );

  mem_map_decoder #(.PAGE_W(7)) dut
  (
    .mclk, .rstn, .clk_en, .rom_select_pin, .ram_overlay_bit(ovl), .rom_to_data_map_bit(map),
    .memory_protect_bit(prot), .vptr_load, .vptr_value, .fetch_req, .fetch_addr,
    .fetch_from_ext, .far_load, .far_target, .tbl_req, .tbl_acc, .tbl_from_ext, .vec_take,
    .vec_num, .data_req, .data_we, .data_addr, .data_wdata, .data_from_ext, .hp_req, .hp_we,
    .hp_addr, .fetch_target, .fetch_phys, .fetch_blk, .tbl_target, .tbl_phys, .tbl_blk,
    .data_target, .data_blk, .data_rdata, .data_rvalid, .spram_conflict, .hp_grant,
    .hp_refused, .pc_load, .pc_value, .program_page_register, .vector_page_pointer,
    .rom_enabled
  );

  // ------------------------------------------------------------
  // clock, hang guard, reporting
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == LIMIT)
    begin
      miscompares = miscompares + 1;
      final_report();
    end
  end

  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // expected decode
  // ------------------------------------------------------------
  // m: rom enabled, overlay, protect, from external
  function automatic mem_map_pkg::target_e pexp(input logic [22:0] a, input logic [3:0] m);
    mem_map_pkg::target_e t;
    t = mem_map_pkg::T_EXT;
    if (m[2] && a[15:0] < 16'h8000)
    begin
      if (a[15:0] > 16'h1FFF)
        t = mem_map_pkg::T_SPRAM;
      else if (a[15:0] > 16'h007F)
        t = mem_map_pkg::T_DPRAM;
    end
    else if (m[3] && a[22:14] == 9'h003)
      t = mem_map_pkg::T_ROM;
    else if (a[22:15] == 8'h03)
      t = mem_map_pkg::T_SPRAM;
    if (m[1] && m[0] && t != mem_map_pkg::T_EXT)
      t = mem_map_pkg::T_BLOCKED;
    return t;
  endfunction

  // m: data map, protect, from external
  function automatic mem_map_pkg::target_e dexp(input logic [15:0] a, input logic [2:0] m);
    mem_map_pkg::target_e t;
    if (a < 16'h0080)
      t = mem_map_pkg::T_MMR;
    else if (a < 16'h2000)
      t = mem_map_pkg::T_DPRAM;
    else if (a < 16'h8000 || m[2])
      t = mem_map_pkg::T_SPRAM;
    else
      t = mem_map_pkg::T_EXT;
    if (m[1] && m[0] && t != mem_map_pkg::T_EXT)
      t = mem_map_pkg::T_BLOCKED;
    return t;
  endfunction

  function automatic logic [2:0] blk(input logic [15:0] a);
    return (a < 16'h2000) ? {1'b0, a[12:11]} : a[15:13] - 3'h1;
  endfunction

  function automatic logic [15:0] rf();
    logic [15:0] a;
    a = 16'($urandom);
    if (a[15:7] == 9'h1FE)
      a[8] = 1'b0;
    return a;
  endfunction

  // f: overlay, map, protect, fetch ext, table ext, data write, data ext, host write
  task automatic access(input logic [15:0] fa, input logic [39:0] ta, input logic [15:0] da,
                        input logic [15:0] wd, input logic [22:0] ha, input logic [7:0] f);
    mem_map_pkg::target_e ft, tt, dt;
    logic [22:0] pa;
    logic [15:0] old;
    logic        rx, cf;
    pa = {page[6:0], fa};
    old = page;
    ft = pexp(pa, {!rom_select_pin, f[7], f[5], f[4]});
    tt = pexp(ta[22:0], {!rom_select_pin, f[7], f[5], f[3]});
    dt = dexp(da, {f[6], f[5], f[1]});
    rx = f[5] && !f[0] && (ha < 23'h001000 || ha > 23'h001FFF);
    cf = dt == mem_map_pkg::T_SPRAM && ((ft == mem_map_pkg::T_SPRAM && blk(fa) == blk(da))
         || (tt == mem_map_pkg::T_SPRAM && blk(ta[15:0]) == blk(da)));
    if (da == 16'h001E && f[2] && dt == mem_map_pkg::T_MMR)
      page = {9'h0, wd[6:0]};
    fork
      begin
        @(posedge mclk);
        {ovl, map, prot} <= f[7:5];
      end
      cpu.fetch(fa, f[4]);
      cpu.tbl(ta, f[3]);
      cpu.data(f[2], da, wd, f[1]);
      cpu.host(f[0], ha);
    join
    #1;
    check(fetch_target, ft);
    if (ft != mem_map_pkg::T_BLOCKED && !(f[7] && fa < 16'h0080))
      check(fetch_phys, (f[7] && fa < 16'h8000) ? {7'h0, fa} : pa);
    if (ft == mem_map_pkg::T_DPRAM || ft == mem_map_pkg::T_SPRAM)
      check(fetch_blk, blk(fa));
    check(tbl_target, tt);
    check(tbl_phys, (f[7] && ta[15:0] < 16'h8000) ? {7'h0, ta[15:0]} : ta[22:0]);
    if (tt == mem_map_pkg::T_DPRAM || tt == mem_map_pkg::T_SPRAM)
      check(tbl_blk, blk(ta[15:0]));
    check(data_target, dt);
    if (dt == mem_map_pkg::T_DPRAM || dt == mem_map_pkg::T_SPRAM)
      check(data_blk, blk(da));
    check(spram_conflict, cf);
    check(hp_refused, rx);
    check(hp_grant, !rx);
    check(data_rvalid, dt == mem_map_pkg::T_MMR && !f[2]);
    if (da == 16'h001E && dt == mem_map_pkg::T_MMR && !f[2])
      check(data_rdata, old);
    check(program_page_register, page);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    r = $urandom(29);
    {rstn, ovl, map, prot, rom_select_pin, cycles, miscompares, cmp_count} = '0;
    clk_en = 1'b1;
    page = 16'h0;
    ptr = 9'h1FF;
    hl = '{23'h000FFF, 23'h001000, 23'h001FFF, 23'h002000};
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    check(pc_load, 1'b1);
    check(pc_value, 16'hFF80);
    check(vector_page_pointer, 9'h1FF);
    check(program_page_register, 16'h0);
    check(rom_enabled, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      if (i > 2)
      begin
        ptr = 9'($urandom);
        cpu.ctl(2'd2, {14'h0, ptr});
      end
      n = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
      cpu.ctl(2'd1, {18'h0, n});
      #1;
      check(pc_load, 1'b1);
      check(pc_value, {ptr, n, 2'b00});
      check(vector_page_pointer, ptr);
      check(program_page_register, page);
    end
    for (int i = 0; i < 5; i++)
      access(rf(), 40'h0, 16'h1000, 16'h0, hl[i % 4], {7'h10, i == 4});
    for (int i = 0; i < 300; i++)
    begin
      if (i % 16 == 0)
      begin
        tgt = {7'($urandom % 3), 16'($urandom)};
        cpu.ctl(2'd0, tgt);
        page = {9'h0, tgt[22:16]};
      end
      access(rf(), {17'($urandom), 7'($urandom % 3), rf()},
             (($urandom % 8) == 0) ? 16'h001E : 16'($urandom), 16'($urandom),
             (($urandom % 2) == 0) ? hl[$urandom % 4] : 23'($urandom), 8'($urandom));
    end
    @(posedge mclk);
    clk_en <= 1'b0;
    cpu.ctl(2'd0, 23'h7F0000);
    #1;
    check(program_page_register, page);
    check(pc_load, 1'b0);
    @(posedge mclk);
    clk_en <= 1'b1;
    @(posedge mclk);
    {rom_select_pin, rstn} <= 2'b10;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    page = 16'h0;
    @(posedge mclk);
    #1;
    check(rom_enabled, 1'b0);
    check(program_page_register, 16'h0);
    access(16'hC000, 40'h00C000, 16'h8000, 16'h0, 23'h0, 8'h0);
    final_report();
  end
endmodule
